/* File: rtl/tpw_top.sv */
/*
  tpw_top: three-phase centre-aligned pwm timing unit with output control,
  registers on a classic wishbone slave, one core clock, synchronous reset.
  assumes the gate drivers take the six pins as active-high on commands.
*/
// Our own choices: register access over Wishbone and the register offsets.
// Behaviour
// - half-period value counts core clocks per half
// - control bit 2 selects single or double update
// - sync each period, also mid-period in double
// - ten-bit shared dead time register
// - single update uses same values both halves
// - dead time moves both edges from duty instant
// - on times follow half-period, duty, dead time
// - on times clamp between zero and full period
// - double update: each half uses own values
// - double update inserts dead time likewise
// - phases one and two built like phase zero
// - no outputs until all four registers written
// - half-period write starts timer, delayed first sync
// - status bit 0 shows second half
// - nine-bit output enable and crossover register
// - bits 8, 7, 6 crossover phases 0, 1, 2
// - crossover swaps high and low pins
// - crossover bits clear after reset
// - set disable bit holds its pin low
// - disable applies after crossover
// - disable bits clear after reset
// - output enable latched on sync pulse
// - bits 0 and 1 disable phase 2 pair
module tpw_top
  import tpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic phase0_high_out_o,
  output logic phase0_low_out_o,
  output logic phase1_high_out_o,
  output logic phase1_low_out_o,
  output logic phase2_high_out_o,
  output logic phase2_low_out_o,
  output logic cycle_sync_pulse_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic ctrl_mode;
  logic [HP_W-1:0] half_period_reg;
  logic [DT_W-1:0] dead_time_reg;
  logic [DUTY_W-1:0] phase0_duty_reg;
  logic [DUTY_W-1:0] phase1_duty_reg;
  logic [DUTY_W-1:0] phase2_duty_reg;
  logic [OE_W-1:0] output_enable_crossover;
  logic [3:0] written;
  logic all_written;
  logic wr_en;
  logic hp_wr;
  logic [31:0] hp_word;
  logic [31:0] ctrl_word, dt_word, duty0_word, duty1_word, duty2_word, oe_word;
  logic [HP_W-1:0] act_hp;
  logic [DT_W-1:0] act_dt;
  logic [DUTY_W-1:0] act_duty [3];
  logic [OE_W-1:0] act_oe;
  tpw_state_e state;
  tpw_state_e next_state;
  logic [HP_W-1:0] cnt;
  logic [HP_W-1:0] next_cnt;
  logic half;
  logic next_half;
  logic [START_W-1:0] start_cnt;
  logic [START_W-1:0] next_start;
  logic sync_now;
  logic run;
  logic [2:0] pin_hi;
  logic [2:0] pin_lo;
  logic [2:0] xover;
  logic [2:0] dis_hi;
  logic [2:0] dis_lo;

  // startup delay: one and a half halves in single, one half in double
  function automatic logic [START_W-1:0] start_delay(input logic [HP_W-1:0] hp,
                                                     input logic dbl);
    logic [START_W-1:0] d;
    d = {1'b0, hp};
    if (!dbl) begin
      d = d + {2'b00, hp[HP_W-1:1]};
    end
    return d - 17'h00001;
  endfunction : start_delay

  // ************************************************************
  // wishbone slave
  // ************************************************************
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign hp_wr = wr_en && (wb_adr_i == ADDR_HALF_PERIOD);
  assign hp_word = tpw_apply_sel({16'h0000, half_period_reg}, wb_dat_i, wb_sel_i);
  assign ctrl_word = tpw_apply_sel(32'(ctrl_mode) << CTRL_MODE_BIT, wb_dat_i, wb_sel_i);
  assign dt_word = tpw_apply_sel({22'h000000, dead_time_reg}, wb_dat_i, wb_sel_i);
  assign duty0_word = tpw_apply_sel({16'h0000, phase0_duty_reg}, wb_dat_i, wb_sel_i);
  assign duty1_word = tpw_apply_sel({16'h0000, phase1_duty_reg}, wb_dat_i, wb_sel_i);
  assign duty2_word = tpw_apply_sel({16'h0000, phase2_duty_reg}, wb_dat_i, wb_sel_i);
  assign oe_word = tpw_apply_sel({23'h000000, output_enable_crossover}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      if (wb_adr_i == ADDR_CONTROL) begin
        wb_dat_o <= 32'(ctrl_mode) << CTRL_MODE_BIT;
      end else if (wb_adr_i == ADDR_STATUS) begin
        wb_dat_o <= (32'(half) << STAT_HALF_BIT) | (32'(run) << STAT_RUN_BIT);
      end else if (wb_adr_i == ADDR_HALF_PERIOD) begin
        wb_dat_o <= {16'h0000, half_period_reg};
      end else if (wb_adr_i == ADDR_DEAD_TIME) begin
        wb_dat_o <= {22'h000000, dead_time_reg};
      end else if (wb_adr_i == ADDR_DUTY0) begin
        wb_dat_o <= {16'h0000, phase0_duty_reg};
      end else if (wb_adr_i == ADDR_DUTY1) begin
        wb_dat_o <= {16'h0000, phase1_duty_reg};
      end else if (wb_adr_i == ADDR_DUTY2) begin
        wb_dat_o <= {16'h0000, phase2_duty_reg};
      end else if (wb_adr_i == ADDR_OUT_ENABLE) begin
        wb_dat_o <= {23'h000000, output_enable_crossover};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_mode <= CTRL_MODE_RST;
      half_period_reg <= HP_RST;
      dead_time_reg <= DT_RST;
      phase0_duty_reg <= DUTY_RST;
      phase1_duty_reg <= DUTY_RST;
      phase2_duty_reg <= DUTY_RST;
      output_enable_crossover <= OE_RST;
    end else if (wr_en) begin
      if (wb_adr_i == ADDR_CONTROL) begin
        ctrl_mode <= ctrl_word[CTRL_MODE_BIT];
      end else if (wb_adr_i == ADDR_HALF_PERIOD) begin
        half_period_reg <= hp_word[HP_W-1:0];
      end else if (wb_adr_i == ADDR_DEAD_TIME) begin
        dead_time_reg <= dt_word[DT_W-1:0];
      end else if (wb_adr_i == ADDR_DUTY0) begin
        phase0_duty_reg <= duty0_word[DUTY_W-1:0];
      end else if (wb_adr_i == ADDR_DUTY1) begin
        phase1_duty_reg <= duty1_word[DUTY_W-1:0];
      end else if (wb_adr_i == ADDR_DUTY2) begin
        phase2_duty_reg <= duty2_word[DUTY_W-1:0];
      end else if (wb_adr_i == ADDR_OUT_ENABLE) begin
        output_enable_crossover <= oe_word[OE_W-1:0];
      end
    end
  end

  // written-once flags for half-period and the three duties
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      written <= 4'h0;
    end else if (wr_en) begin
      if (wb_adr_i == ADDR_HALF_PERIOD) begin
        written[0] <= 1'b1;
      end else if (wb_adr_i == ADDR_DUTY0) begin
        written[1] <= 1'b1;
      end else if (wb_adr_i == ADDR_DUTY1) begin
        written[2] <= 1'b1;
      end else if (wb_adr_i == ADDR_DUTY2) begin
        written[3] <= 1'b1;
      end
    end
  end

  assign all_written = &written;

  // ************************************************************
  // main timer
  // ************************************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_half = half;
    next_start = start_cnt;
    sync_now = 1'b0;
    case (state)
      ST_IDLE: begin
        if (hp_wr) begin
          next_state = ST_START;
          next_start = start_delay(hp_word[HP_W-1:0], ctrl_mode);
        end
      end
      ST_START: begin
        if (hp_wr) begin
          next_start = start_delay(hp_word[HP_W-1:0], ctrl_mode);
        end else if (start_cnt != 17'h00000) begin
          next_start = start_cnt - 17'h00001;
        end else if (all_written) begin
          next_state = ST_RUN;
          next_cnt = 16'h0000;
          next_half = 1'b0;
          sync_now = 1'b1;
        end
      end
      ST_RUN: begin
        if (!half) begin
          if (cnt >= act_hp - 16'h0001) begin
            next_half = 1'b1;
            if (ctrl_mode) begin
              sync_now = 1'b1;
              next_cnt = half_period_reg - 16'h0001;
            end else begin
              next_cnt = act_hp - 16'h0001;
            end
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end else begin
          if (cnt == 16'h0000) begin
            next_half = 1'b0;
            next_cnt = 16'h0000;
            sync_now = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      half <= 1'b0;
      start_cnt <= 17'h00000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      half <= next_half;
      start_cnt <= next_start;
    end
  end

  // ************************************************************
  // sync pulse and latching
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cycle_sync_pulse_o <= 1'b0;
    end else begin
      cycle_sync_pulse_o <= sync_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_hp <= HP_RST;
      act_dt <= DT_RST;
      act_duty[0] <= DUTY_RST;
      act_duty[1] <= DUTY_RST;
      act_duty[2] <= DUTY_RST;
      act_oe <= OE_RST;
    end else if (sync_now) begin
      act_hp <= half_period_reg;
      act_dt <= dead_time_reg;
      act_duty[0] <= phase0_duty_reg;
      act_duty[1] <= phase1_duty_reg;
      act_duty[2] <= phase2_duty_reg;
      act_oe <= output_enable_crossover;
    end
  end

  assign run = (state == ST_RUN);

  // ************************************************************
  // output control and phase pairs
  // ************************************************************
  assign xover = {act_oe[OE_XOVER_P2], act_oe[OE_XOVER_P1], act_oe[OE_XOVER_P0]};
  assign dis_hi = {act_oe[OE_DIS_P2H], act_oe[OE_DIS_P1H], act_oe[OE_DIS_P0H]};
  assign dis_lo = {act_oe[OE_DIS_P2L], act_oe[OE_DIS_P1L], act_oe[OE_DIS_P0L]};

  for (genvar p = 0; p < 3; p++) begin : g_phase
    tpw_phase u_phase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run && all_written),
      .cnt_i(cnt),
      .hp_i(act_hp),
      .dt_i(act_dt),
      .duty_i(act_duty[p]),
      .xover_i(xover[p]),
      .dis_hi_i(dis_hi[p]),
      .dis_lo_i(dis_lo[p]),
      .hi_o(pin_hi[p]),
      .lo_o(pin_lo[p])
    );
  end

  assign phase0_high_out_o = pin_hi[0];
  assign phase0_low_out_o = pin_lo[0];
  assign phase1_high_out_o = pin_hi[1];
  assign phase1_low_out_o = pin_lo[1];
  assign phase2_high_out_o = pin_hi[2];
  assign phase2_low_out_o = pin_lo[2];

  // ************************************************************
  // assertions
  // ************************************************************
  mid_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(half) |-> (cycle_sync_pulse_o == $past(ctrl_mode)))
    else $error("mid-period sync does not follow update mode");

  sync_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_sync_pulse_o |-> (act_hp == $past(half_period_reg)) && (act_dt == $past(dead_time_reg)))
    else $error("period values not latched on sync");

  oe_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(act_oe) |-> cycle_sync_pulse_o)
    else $error("output enable changed without sync");

  status_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && $past(run) && $fell(half)) |-> cycle_sync_pulse_o)
    else $error("period start without sync pulse");

  idle_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !all_written |=> !(|pin_hi) && !(|pin_lo))
    else $error("output active before all registers written");

  oe_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> (output_enable_crossover == 9'h000) && (act_oe == 9'h000))
    else $error("output enable not cleared by reset");

  start_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_IDLE && hp_wr && !ctrl_mode && hp_word[HP_W-1:0] == 16'h0014)
    |=> (state == ST_START && start_cnt == 17'h0001D))
    else $error("startup delay wrong");

  count_span_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && !half && !sync_now && $past(run) && !$past(half)) |-> (cnt == $past(cnt) + 16'h0001))
    else $error("first-half counter does not step by one");

endmodule : tpw_top

/* File: rtl/tpw_pkg.sv */
/*
  tpw_pkg: register map, field positions, reset values, widths and states
  of the three-phase centre-aligned pwm timing and output control block.
  assumes a 32-bit classic wishbone slave with byte addresses on 8 bits.
*/
package tpw_pkg;

  // ************************************************************
  // clock and widths
  // ************************************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int HP_W = 16;
  localparam int DT_W = 10;
  localparam int DUTY_W = 16;
  localparam int OE_W = 9;
  localparam int CMP_W = 19;
  localparam int START_W = 17;
  localparam int ADR_W = 8;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_HALF_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_DEAD_TIME = 8'h0C;
  localparam logic [7:0] ADDR_DUTY0 = 8'h10;
  localparam logic [7:0] ADDR_DUTY1 = 8'h14;
  localparam logic [7:0] ADDR_DUTY2 = 8'h18;
  localparam logic [7:0] ADDR_OUT_ENABLE = 8'h1C;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_MODE_BIT = 2;
  localparam int STAT_HALF_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int OE_XOVER_P0 = 8;
  localparam int OE_XOVER_P1 = 7;
  localparam int OE_XOVER_P2 = 6;
  localparam int OE_DIS_P2L = 0;
  localparam int OE_DIS_P2H = 1;
  localparam int OE_DIS_P1H = 2;
  localparam int OE_DIS_P1L = 3;
  localparam int OE_DIS_P0H = 4;
  localparam int OE_DIS_P0L = 5;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic [HP_W-1:0] HP_RST = 16'h0000;
  localparam logic [DT_W-1:0] DT_RST = 10'h000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
  localparam logic [OE_W-1:0] OE_RST = 9'h000;

  // ************************************************************
  // timer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN
  } tpw_state_e;

  // byte-lane merge of a wishbone write into an old word
  function automatic logic [31:0] tpw_apply_sel(input logic [31:0] old_val,
                                                input logic [31:0] wdat,
                                                input logic [3:0] sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction : tpw_apply_sel

endpackage : tpw_pkg

/* File: rtl/tpw_phase.sv */
/*
  tpw_phase: one output pair: dead-time compare against the shared counter,
  crossover and per-pin disable, registered pin drive.
  assumes the counter counts up in the first half and down in the second.
*/
module tpw_phase
  import tpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [HP_W-1:0] cnt_i,
  input wire logic [HP_W-1:0] hp_i,
  input wire logic [DT_W-1:0] dt_i,
  input wire logic [DUTY_W-1:0] duty_i,
  input wire logic xover_i,
  input wire logic dis_hi_i,
  input wire logic dis_lo_i,
  output logic hi_o,
  output logic lo_o
);

  logic signed [CMP_W-1:0] twice_cnt;
  logic signed [CMP_W-1:0] thr_hi;
  logic signed [CMP_W-1:0] thr_lo;
  logic raw_hi;
  logic raw_lo;

  // ************************************************************
  // compare with dead time
  // ************************************************************
  always_comb begin
    twice_cnt = $signed({2'b00, cnt_i, 1'b0});
    thr_hi = $signed({3'b000, hp_i}) - $signed({2'b00, duty_i, 1'b0})
             + $signed({8'h00, dt_i, 1'b0});
    thr_lo = $signed({3'b000, hp_i}) - $signed({2'b00, duty_i, 1'b0})
             - $signed({8'h00, dt_i, 1'b0});
    raw_hi = run_i && (twice_cnt >= thr_hi);
    raw_lo = run_i && (twice_cnt < thr_lo);
  end

  // ************************************************************
  // crossover then disable
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_o <= 1'b0;
      lo_o <= 1'b0;
    end else begin
      hi_o <= !dis_hi_i && (xover_i ? raw_lo : raw_hi);
      lo_o <= !dis_lo_i && (xover_i ? raw_hi : raw_lo);
    end
  end

  no_overlap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(raw_hi && raw_lo))
    else $error("high and low timing signals overlap");

  pin_disable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dis_hi_i || dis_lo_i) |=> !((hi_o && $past(dis_hi_i)) || (lo_o && $past(dis_lo_i))))
    else $error("disabled output not held low");

  crossover_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (xover_i && !dis_hi_i && !dis_lo_i) |=> (hi_o == $past(raw_lo)) && (lo_o == $past(raw_hi)))
    else $error("crossover routing wrong");

endmodule : tpw_phase

/* File: bench/tpw_gate_model.sv */
/*
  tpw_gate_model: gate driver side of the six pwm pins; counts on cycles
  per pin and cycles between sync pulses, flags a pair that is fully on.
  assumes pins are active-high on commands, sampled on the core clock.
*/
module tpw_gate_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] gate_i,
  input wire logic sync_i,
  output logic [5:0][15:0] on_o,
  output logic [15:0] period_o,
  output logic shoot_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0][15:0] acc;
  logic [15:0] len;

  // ****************************************
  // on-time and period measurement per window
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= '0;
      on_o <= '0;
      len <= 16'h0000;
      period_o <= 16'h0000;
    end else begin
      for (int i = 0; i < 6; i++) begin
        acc[i] <= sync_i ? 16'h0000 : acc[i] + 16'(gate_i[i]);
        if (sync_i) begin
          on_o[i] <= acc[i] + 16'(gate_i[i]);
        end
      end
      len <= sync_i ? 16'h0000 : len + 16'h0001;
      if (sync_i) begin
        period_o <= len + 16'h0001;
      end
    end
  end

  // both switches of one leg on would short the supply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shoot_o <= 1'b0;
    end else if ((gate_i[0] & gate_i[1]) | (gate_i[2] & gate_i[3]) |
                 (gate_i[4] & gate_i[5])) begin
      shoot_o <= 1'b1;
    end
  end
endmodule : tpw_gate_model

/* File: bench/tpw_top_test.sv */
/*
  tpw_top_test: self-checking bench of the pwm block over classic wishbone.
  assumes the gate model beside the pins and a 100 MHz core clock.
*/
module tpw_top_test
  import tpw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, sync;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0, wb_rdat, rd;
  logic [5:0] gates;
  logic [5:0][15:0] on;
  logic [15:0] period;
  logic shoot;
  logic [8:0] oe;
  int miscompares = 0, compares = 0, cyc_n = 0, first_sync = -1, ack_cyc, hp, dt, a;
  int du[3];
  int seed;
  int dis_idx[6] = '{OE_DIS_P0H, OE_DIS_P0L, OE_DIS_P1H, OE_DIS_P1L, OE_DIS_P2H, OE_DIS_P2L};
  int xb[3] = '{OE_XOVER_P0, OE_XOVER_P1, OE_XOVER_P2};
  logic [8:0] oe_tab[4] = '{9'h000, 9'h1C0, 9'h0A7, 9'h03F};

  tpw_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .phase0_high_out_o(gates[0]),
    .phase0_low_out_o(gates[1]), .phase1_high_out_o(gates[2]),
    .phase1_low_out_o(gates[3]), .phase2_high_out_o(gates[4]),
    .phase2_low_out_o(gates[5]), .cycle_sync_pulse_o(sync));
  tpw_gate_model gate_drv (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gates), .sync_i(sync),
    .on_o(on), .period_o(period), .shoot_o(shoot));

  // ****************************************
  // clock, cycle count, first sync
  // ****************************************
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    cyc_n++;
    if (sync === 1'b1 && first_sync < 0) first_sync = cyc_n;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic conclude();
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    if (n == 20) begin
      chk(0, 1, "bus wait ran out");
      conclude();
    end
    rd = wb_rdat;
    ack_cyc = cyc_n;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : xfer
  task automatic wait_sync(input int k);
    int n;
    repeat (k) begin
      for (n = 0; n < 400; n++) begin
        @(posedge clk_i);
        if (sync === 1'b1) break;
      end
      if (n == 400) begin
        chk(0, 1, "sync wait ran out");
        conclude();
      end
    end
  endtask : wait_sync
  function automatic int on_exp(int p, int d, int t, bit hi);
    int v;
    v = hi ? p + 2 * (d - t) : p - 2 * (d + t);
    if (v < 0) v = 0;
    if (v > 2 * p) v = 2 * p;
    return v;
  endfunction : on_exp
  task automatic check_win(input int div);
    int v;
    wait_sync(3);
    @(negedge clk_i);
    chk(32'(period), 32'(2 * hp / div), "sync spacing");
    for (int k = 0; k < 6; k++) begin
      v = on_exp(hp, du[k / 2], dt, (k % 2 == 0) ^ oe[xb[k / 2]]) / div;
      if (oe[dis_idx[k]]) v = 0;
      chk(32'(on[k]), 32'(v), "pin on time");
    end
  endtask : check_win
  task automatic load();
    xfer(1'b1, ADDR_DEAD_TIME, 32'(dt));
    xfer(1'b1, ADDR_DUTY0, 32'(du[0]));
    xfer(1'b1, ADDR_DUTY1, 32'(du[1]));
    xfer(1'b1, ADDR_DUTY2, 32'(du[2]));
    xfer(1'b1, ADDR_OUT_ENABLE, 32'(oe));
  endtask : load

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'hF94F2191;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i <= 8; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    xfer(1'b1, ADDR_DUTY0, 32'h5);
    xfer(1'b1, ADDR_DUTY1, 32'h5);
    repeat (60) @(posedge clk_i);
    chk(32'(first_sync), 32'hFFFFFFFF, "sync before setup");
    chk(32'(gates), 32'h0, "pins before setup");
    hp = 20;
    xfer(1'b1, ADDR_HALF_PERIOD, 32'(hp));
    a = ack_cyc;
    xfer(1'b1, ADDR_DUTY2, 32'h5);
    wait_sync(1);
    chk(32'(first_sync - a - 1), 32'(hp + hp / 2), "first sync delay");
    xfer(1'b1, ADDR_DEAD_TIME, 32'hFFFFFFFF);
    xfer(1'b0, ADDR_DEAD_TIME, 32'h0);
    chk(rd, 32'h3FF, "dead time width");
    xfer(1'b1, ADDR_OUT_ENABLE, 32'hFFFFFFFF);
    xfer(1'b0, ADDR_OUT_ENABLE, 32'h0);
    chk(rd, 32'h1FF, "enable width");
    for (int i = 0; i < 8; i++) begin
      hp = 16 + 2 * ($unsigned($random(seed)) % 12);
      dt = $unsigned($random(seed)) % 6;
      foreach (du[j]) du[j] = $unsigned($random(seed)) % (hp / 2 + 5);
      if (i == 0) du = '{0, hp, hp / 2};
      oe = (i < 4) ? oe_tab[i] : 9'($random(seed));
      xfer(1'b1, ADDR_HALF_PERIOD, 32'(hp));
      load();
      check_win(1);
    end
    wait_sync(1);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0, "status first half");
    repeat (hp) @(posedge clk_i);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1, "status second half");
    du = '{hp, hp, hp};
    oe = 9'h000;
    load();
    wait_sync(3);
    xfer(1'b1, ADDR_OUT_ENABLE, 32'h03F);
    repeat (5) @(posedge clk_i);
    chk(32'(gates), 32'h15, "enable before sync");
    wait_sync(1);
    repeat (3) @(posedge clk_i);
    chk(32'(gates), 32'h0, "disabled pins");
    du = '{3, 7, 1};
    dt = 2;
    oe = 9'h100;
    load();
    xfer(1'b1, ADDR_CONTROL, 32'h4);
    check_win(2);
    chk(32'(shoot), 32'h0, "leg overlap");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    first_sync = -1;
    xfer(1'b0, ADDR_OUT_ENABLE, 32'h0);
    chk(rd, 32'h0, "enable after reset");
    xfer(1'b1, ADDR_CONTROL, 32'h4);
    xfer(1'b1, ADDR_HALF_PERIOD, 32'(hp));
    a = ack_cyc;
    load();
    wait_sync(1);
    chk(32'(first_sync - a - 1), 32'(hp), "first sync delay double");
    conclude();
  end
endmodule : tpw_top_test
